// file: dv/sml_host_model.sv
// Purpose: management processor owning the static table contents
// Assumes: one strobe cycle per access
// Notes: address and data idle at the inverse of the last value
`timescale 1ns/1ps
`default_nettype none

module sml_host_model (
  input  wire logic       sys_clk_i,
  output logic      [7:0] reg_addr_o,
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial
  begin
    {reg_addr_o, reg_wr_o, reg_rd_o, reg_wdata_o} = 18'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
    @(posedge sys_clk_i);
    #1;
    {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_i);
    #1;
    {reg_addr_o, reg_rd_o} = {a, 1'b1};
    @(posedge sys_clk_i);
    #1;
    {reg_addr_o, reg_rd_o} = {~a, 1'b0};
    d = reg_rvalid_i ? reg_rdata_i : 8'hxx;
  endtask

  task automatic write_entry(input logic [2:0] idx, input logic [57:0] e);
    logic [63:0] w;
    w = {6'h00, e};
    for (int k = 0; k < 8; k++)
    begin
      wr(sml_pkg::ADDR_DATA_FIRST + 8'(k), w[63-8*k -: 8]);
    end
    wr(sml_pkg::ADDR_TBL_CTRL, 8'h00);
    wr(sml_pkg::ADDR_TBL_INDEX, {5'h00, idx});
  endtask

  task automatic read_entry(input logic [2:0] idx, output logic [57:0] e);
    logic [63:0] r;
    wr(sml_pkg::ADDR_TBL_CTRL, 8'h10);
    wr(sml_pkg::ADDR_TBL_INDEX, {5'h00, idx});
    for (int k = 0; k < 8; k++)
    begin
      rd(sml_pkg::ADDR_DATA_FIRST + 8'(k), r[63-8*k -: 8]);
    end
    e = r[57:0];
  endtask
endmodule // sml_host_model

`default_nettype wire

// file: dv/sml_lookup_asserts.sv
// Purpose: port-level checks of lookup answers and register side effects
// Assumes: one clock, synchronous active-high reset
// Notes: bound into sml_lookup_top
`timescale 1ns/1ps
`default_nettype none

module sml_lookup_asserts (
  input wire logic       sys_clk_i,
  input wire logic       sys_rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_rvalid_o,
  input wire logic       lookup_req_i,
  input wire logic [1:0] origin_port_i,
  input wire logic       vlan_mode_i,
  input wire logic       vlan_valid_i,
  input wire logic [2:0] vlan_members_i,
  input wire logic       dyn_hit_i,
  input wire logic [2:0] dyn_ports_i,
  input wire logic       src_dyn_hit_i,
  input wire logic       fwd_valid_o,
  input wire logic [2:0] fwd_ports_o,
  input wire logic       fwd_drop_o,
  input wire logic       fwd_override_o,
  input wire logic       fwd_static_hit_o,
  input wire logic       learn_source_o,
  input wire logic [5:0] tag_insert_o
);
  logic [2:0] ing_m;
  logic       bad_vlan;

  assign ing_m    = 3'h1 << origin_port_i;
  assign bad_vlan = vlan_mode_i & ~vlan_valid_i;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_answer_next: assert property (lookup_req_i |=> fwd_valid_o) else $error("no answer after lookup");
  a_answer_cause: assert property (fwd_valid_o |-> $past(lookup_req_i)) else $error("answer without lookup");
  a_learn_pulse: assert property (learn_source_o |-> fwd_valid_o) else $error("learn outside answer");
  a_learn_value: assert property (lookup_req_i |=> learn_source_o == (!$past(src_dyn_hit_i) && !$past(bad_vlan)))
    else $error("learn decision wrong");
  a_bad_vlan_drop: assert property (lookup_req_i && bad_vlan |=> !fwd_static_hit_o && !learn_source_o
    && fwd_drop_o == (fwd_ports_o == 3'h0) && (fwd_ports_o & $past(ing_m)) == 3'h0)
    else $error("invalid vlan frame not handled");
  a_dyn_result: assert property (lookup_req_i && !bad_vlan && dyn_hit_i |=>
    fwd_static_hit_o || fwd_ports_o == $past(dyn_ports_i)) else $error("dynamic result lost");
  a_flood_members: assert property (lookup_req_i && !bad_vlan && !dyn_hit_i |=>
    fwd_static_hit_o || fwd_ports_o == ($past(vlan_members_i) & ~$past(ing_m))) else $error("flood mask wrong");
  a_override_static: assert property (fwd_override_o |-> fwd_static_hit_o) else $error("override without hit");
  a_tag_write: assert property (reg_wr_i && reg_addr_i == sml_pkg::ADDR_TAG_INSERT |=>
    {2'h0, tag_insert_o} == ($past(reg_wdata_i) & 8'h3f)) else $error("tag insert not written");
  a_tag_hold: assert property (!$past(reg_wr_i) |-> $stable(tag_insert_o)) else $error("tag insert moved");
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");

  c_static_hit: cover property (fwd_valid_o && fwd_static_hit_o && fwd_override_o);
  c_drop: cover property (fwd_valid_o && fwd_drop_o);
  c_read: cover property (reg_rvalid_o);
endmodule // sml_lookup_asserts

bind sml_lookup_top sml_lookup_asserts u_chk (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_rvalid_o, .lookup_req_i, .origin_port_i, .vlan_mode_i, .vlan_valid_i, .vlan_members_i,
  .dyn_hit_i, .dyn_ports_i, .src_dyn_hit_i, .fwd_valid_o, .fwd_ports_o, .fwd_drop_o, .fwd_override_o,
  .fwd_static_hit_o, .learn_source_o, .tag_insert_o);

`default_nettype wire

// file: dv/sml_lookup_top_tb_top.sv
// Purpose: directed tests of static table lookups and egress controls
// Assumes: 100 MHz clock, reset held 16 cycles
// Notes: table contents set through the host model
`timescale 1ns/1ps
`default_nettype none

module sml_lookup_top_tb_top;
  logic        sys_clk_i, sys_rst_i, reg_wr_i, reg_rd_i, reg_rvalid_o, lookup_req_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, d;
  logic [47:0] destination_station_i;
  logic [3:0]  filter_group_id_i;
  logic [1:0]  origin_port_i;
  logic [2:0]  vlan_members_i, dyn_ports_i, fwd_ports_o;
  logic        vlan_mode_i, vlan_valid_i, dyn_hit_i, src_dyn_hit_i;
  logic        fwd_valid_o, fwd_drop_o, fwd_override_o, fwd_static_hit_o, learn_source_o;
  logic [5:0]  tag_insert_o;
  logic [57:0] e;
  int          mismatches, num_checks;
  localparam logic [47:0] MA = 48'h0a0b0c0d0e0f, MB = 48'h112233445566, MC = 48'h665544332211;

  sml_host_model host (.sys_clk_i, .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
    .reg_wdata_o(reg_wdata_i), .reg_rdata_i(reg_rdata_o), .reg_rvalid_i(reg_rvalid_o));

  sml_lookup_top DUT (.sys_clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o,
    .reg_rvalid_o, .lookup_req_i, .destination_station_i, .filter_group_id_i, .origin_port_i, .vlan_mode_i,
    .vlan_valid_i, .vlan_members_i, .dyn_hit_i, .dyn_ports_i, .src_dyn_hit_i, .fwd_valid_o, .fwd_ports_o,
    .fwd_drop_o, .fwd_override_o, .fwd_static_hit_o, .learn_source_o, .tag_insert_o);

  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
    begin
      $display("ALL TESTS PASSED");
    end
    else
    begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic look(input logic [47:0] da, input logic [3:0] grp, input logic [1:0] org, input logic dh,
                      input logic [2:0] dp, input logic [2:0] ep, input logic es, input logic eo, input logic ed);
    @(posedge sys_clk_i);
    #1;
    {destination_station_i, filter_group_id_i, origin_port_i, dyn_hit_i, dyn_ports_i} = {da, grp, org, dh, dp};
    lookup_req_i = 1'b1;
    @(posedge sys_clk_i);
    #1;
    lookup_req_i = 1'b0;
    check("fwd_valid", fwd_valid_o, 1'b1);
    check("fwd_ports", fwd_ports_o, ep);
    check("static_hit", fwd_static_hit_o, es);
    check("override", fwd_override_o, eo);
    check("drop", fwd_drop_o, ed);
    check("learn", learn_source_o, !src_dyn_hit_i && !(vlan_mode_i && !vlan_valid_i));
  endtask

  initial
  begin
    #1000000;
    mismatches++;
    finish_test();
  end

  initial
  begin
    {sys_rst_i, lookup_req_i, vlan_mode_i, vlan_valid_i, src_dyn_hit_i, vlan_members_i} = {5'h10, 3'h7};
    {destination_station_i, filter_group_id_i, origin_port_i, dyn_hit_i, dyn_ports_i} = 58'h0;
    repeat (16) @(posedge sys_clk_i);
    #1;
    sys_rst_i = 1'b0;
    check("tag_reset", tag_insert_o, 6'h00);
    host.rd(sml_pkg::ADDR_BAD_VLAN, d);
    check("bad_vlan_reset", d, 8'h00);
    host.rd(8'h00, d);
    check("unmapped", d, 8'h00);
    host.read_entry(3'h3, e);
    check("entry_reset", e, 58'h0);
    $display("test reset done");
    for (int i = 0; i < 6; i++)
    begin
      host.wr(sml_pkg::ADDR_TAG_INSERT, 8'h01 << i);
      check("tag_bit", tag_insert_o, 6'h01 << i);
    end
    host.wr(sml_pkg::ADDR_TAG_INSERT, 8'hff);
    host.rd(sml_pkg::ADDR_TAG_INSERT, d);
    check("tag_read", d, 8'h3f);
    host.wr(sml_pkg::ADDR_BAD_VLAN, 8'hff);
    host.rd(sml_pkg::ADDR_BAD_VLAN, d);
    check("bad_vlan_read", d, 8'h70);
    host.wr(sml_pkg::ADDR_BAD_VLAN, 8'h00);
    $display("test registers done");
    host.write_entry(3'h0, {4'h0, 3'b011, 3'h2, MA});
    host.write_entry(3'h1, {4'h0, 3'b001, 3'h4, MA});
    host.write_entry(3'h2, {4'h5, 3'b101, 3'h7, MB});
    host.write_entry(3'h3, {4'h0, 3'b000, 3'h1, MC});
    host.read_entry(3'h2, e);
    check("entry_read", e, {4'h5, 3'b101, 3'h7, MB});
    look(MA, 4'h0, 2'h0, 1'b1, 3'h1, 3'h2, 1'b1, 1'b1, 1'b0);
    look(MB, 4'h5, 2'h0, 1'b0, 3'h0, 3'h6, 1'b1, 1'b0, 1'b0);
    vlan_members_i = 3'h3;
    look(MB, 4'h6, 2'h1, 1'b0, 3'h0, 3'h1, 1'b0, 1'b0, 1'b0);
    look(MC, 4'h0, 2'h2, 1'b1, 3'h4, 3'h4, 1'b0, 1'b0, 1'b0);
    src_dyn_hit_i = 1'b1;
    look(MA, 4'h0, 2'h1, 1'b0, 3'h0, 3'h2, 1'b1, 1'b1, 1'b0);
    src_dyn_hit_i = 1'b0;
    $display("test lookups done");
    {vlan_mode_i, vlan_valid_i} = 2'b10;
    look(MA, 4'h0, 2'h0, 1'b1, 3'h1, 3'h0, 1'b0, 1'b0, 1'b1);
    host.wr(sml_pkg::ADDR_BAD_VLAN, 8'h30);
    look(MA, 4'h0, 2'h0, 1'b1, 3'h1, 3'h2, 1'b0, 1'b0, 1'b0);
    vlan_valid_i = 1'b1;
    look(MB, 4'h5, 2'h2, 1'b0, 3'h0, 3'h3, 1'b1, 1'b0, 1'b0);
    vlan_mode_i = 1'b0;
    $display("test vlan done");
    // non-static table select: index write must leave entry 0 alone
    host.wr(sml_pkg::ADDR_TBL_CTRL, 8'h04);
    host.wr(sml_pkg::ADDR_TBL_INDEX, 8'h00);
    repeat (2000) @(posedge sys_clk_i);
    look(MA, 4'h0, 2'h0, 1'b0, 3'h0, 3'h2, 1'b1, 1'b1, 1'b0);
    host.write_entry(3'h0, {4'h0, 3'b010, 3'h2, MA});
    look(MA, 4'h0, 2'h0, 1'b0, 3'h0, 3'h4, 1'b1, 1'b0, 1'b0);
    $display("test persistence done");
    finish_test();
  end
endmodule // sml_lookup_top_tb_top

`default_nettype wire

// file: hw/sml_entry_mem.sv
// Purpose: storage of the static station entries
// Assumes: written only through the register port
// Notes: all entries visible in parallel for lookup; read data registered
`timescale 1ns/1ps
`default_nettype none

module sml_entry_mem #(
  parameter int DEPTH = sml_pkg::ENTRIES,
  parameter int WIDTH = sml_pkg::ENTRY_W
)(
  input  wire logic sys_clk_i,
  input  wire logic sys_rst_i,
  sml_mem_if.mem    mem
);

  logic [WIDTH-1:0] store_reg [DEPTH];
  logic [WIDTH-1:0] store_next [DEPTH];
  logic [WIDTH-1:0] rdata_reg;
  logic [WIDTH-1:0] rdata_next;

  // ------------------------------------------------------------
  // next values
  // ------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      store_next[i] = store_reg[i];
      // only software writes change an entry; nothing ages them
      if (mem.we && (int'(mem.waddr) == i))
      begin
        store_next[i] = mem.wdata;
      end
    end
    rdata_next = mem.re ? store_reg[mem.raddr] : rdata_reg;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        store_reg[i] <= sml_pkg::ENTRY_RESET;
      end
      rdata_reg <= sml_pkg::ENTRY_RESET;
    end
    else
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        store_reg[i] <= store_next[i];
      end
      rdata_reg <= rdata_next;
    end
  end

  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem.entries[i*WIDTH +: WIDTH] = store_reg[i];
    end
  end

  assign mem.rdata = rdata_reg;

endmodule // sml_entry_mem

`default_nettype wire

// file: hw/sml_lookup_top.sv
// Purpose: static station table, destination resolution and egress tag controls
// Assumes: dynamic table and vlan table results arrive with the lookup request
// Notes: register port is byte wide; lookup answer one cycle after request
`timescale 1ns/1ps
`default_nettype none

module sml_lookup_top (
  input  wire logic        sys_clk_i,
  input  wire logic        sys_rst_i,
  // register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // lookup request
  input  wire logic        lookup_req_i,
  input  wire logic [47:0] destination_station_i,
  input  wire logic [3:0]  filter_group_id_i,
  input  wire logic [1:0]  origin_port_i,
  input  wire logic        vlan_mode_i,
  input  wire logic        vlan_valid_i,
  input  wire logic [2:0]  vlan_members_i,
  input  wire logic        dyn_hit_i,
  input  wire logic [2:0]  dyn_ports_i,
  input  wire logic        src_dyn_hit_i,
  // lookup answer
  output logic             fwd_valid_o,
  output logic      [2:0]  fwd_ports_o,
  output logic             fwd_drop_o,
  output logic             fwd_override_o,
  output logic             fwd_static_hit_o,
  output logic             learn_source_o,
  output logic      [5:0]  tag_insert_o
);

  localparam int EW = sml_pkg::ENTRY_W;
  localparam int NE = sml_pkg::ENTRIES;
  localparam int DB = sml_pkg::DATA_BYTES;

  sml_mem_if mem_bus ();

  sml_entry_mem #(
    .DEPTH (NE),
    .WIDTH (EW)
  ) u_entry_mem (
    .sys_clk_i (sys_clk_i),
    .sys_rst_i (sys_rst_i),
    .mem       (mem_bus.mem)
  );

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] data_reg [DB];
  logic [7:0] data_next [DB];
  logic [5:0] tag_reg;
  logic [5:0] tag_next;
  logic [2:0] bad_vlan_port_mask_reg;
  logic [2:0] bad_vlan_port_mask_next;
  logic       fill_reg;
  logic       fill_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rvalid_reg;
  logic       rvalid_next;

  logic [63:0]   data_flat;
  logic          index_hit;
  logic          is_static_sel;
  logic [2:0]    data_sel;
  logic          data_hit;

  always_comb
  begin
    for (int b = 0; b < DB; b++)
    begin
      data_flat[(DB-1-b)*8 +: 8] = data_reg[b];
    end
  end

  assign is_static_sel = (ctrl_reg[sml_pkg::CTRL_SEL_LSB +: 2] == sml_pkg::SEL_STATIC);
  assign index_hit     = (reg_addr_i == sml_pkg::ADDR_TBL_INDEX);
  assign data_hit      = (reg_addr_i >= sml_pkg::ADDR_DATA_FIRST) &&
                         (reg_addr_i < (sml_pkg::ADDR_DATA_FIRST + 8'(DB)));
  assign data_sel      = 3'(reg_addr_i - sml_pkg::ADDR_DATA_FIRST);

  // indirect table access: index write triggers the operation
  assign mem_bus.we    = reg_wr_i && index_hit && is_static_sel &&
                         !ctrl_reg[sml_pkg::CTRL_READ_BIT];
  assign mem_bus.re    = reg_wr_i && index_hit && is_static_sel &&
                         ctrl_reg[sml_pkg::CTRL_READ_BIT];
  assign mem_bus.waddr = reg_wdata_i[sml_pkg::IDX_W-1:0];
  assign mem_bus.raddr = reg_wdata_i[sml_pkg::IDX_W-1:0];
  assign mem_bus.wdata = data_flat[EW-1:0];

  always_comb
  begin
    ctrl_next               = ctrl_reg;
    tag_next                = tag_reg;
    bad_vlan_port_mask_next = bad_vlan_port_mask_reg;
    fill_next               = mem_bus.re;
    rvalid_next             = reg_rd_i;
    rdata_next              = rdata_reg;
    for (int b = 0; b < DB; b++)
    begin
      data_next[b] = data_reg[b];
    end
    if (reg_wr_i)
    begin
      if (reg_addr_i == sml_pkg::ADDR_TBL_CTRL)
      begin
        ctrl_next = reg_wdata_i;
      end
      if (reg_addr_i == sml_pkg::ADDR_TAG_INSERT)
      begin
        tag_next = reg_wdata_i[sml_pkg::TAG_INSERT_W-1:0];
      end
      if (reg_addr_i == sml_pkg::ADDR_BAD_VLAN)
      begin
        bad_vlan_port_mask_next = reg_wdata_i[sml_pkg::BAD_VLAN_LSB +: sml_pkg::PORT_CNT];
      end
      if (data_hit)
      begin
        data_next[data_sel] = reg_wdata_i;
      end
    end
    // table read lands in the data bytes; it wins over a same-cycle byte write
    if (fill_reg)
    begin
      for (int b = 0; b < DB; b++)
      begin
        data_next[b] = 8'({6'h00, mem_bus.rdata} >> ((DB-1-b)*8));
      end
    end
    // upper byte holds only entry bits 57-56
    data_next[0] = data_next[0] & 8'((1 << sml_pkg::TOP_BYTE_W) - 1);
    if (reg_rd_i)
    begin
      rdata_next = 8'h00;
      if (reg_addr_i == sml_pkg::ADDR_TBL_CTRL)
      begin
        rdata_next = ctrl_reg;
      end
      if (reg_addr_i == sml_pkg::ADDR_TAG_INSERT)
      begin
        rdata_next = {2'h0, tag_reg};
      end
      if (reg_addr_i == sml_pkg::ADDR_BAD_VLAN)
      begin
        rdata_next = {1'h0, bad_vlan_port_mask_reg, 4'h0};
      end
      if (data_hit)
      begin
        rdata_next = data_reg[data_sel];
      end
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_reg               <= sml_pkg::REG_RESET;
      tag_reg                <= '0;
      bad_vlan_port_mask_reg <= '0;
      fill_reg               <= 1'b0;
      rdata_reg              <= sml_pkg::REG_RESET;
      rvalid_reg             <= 1'b0;
      for (int b = 0; b < DB; b++)
      begin
        data_reg[b] <= sml_pkg::REG_RESET;
      end
    end
    else
    begin
      ctrl_reg               <= ctrl_next;
      tag_reg                <= tag_next;
      bad_vlan_port_mask_reg <= bad_vlan_port_mask_next;
      fill_reg               <= fill_next;
      rdata_reg              <= rdata_next;
      rvalid_reg             <= rvalid_next;
      for (int b = 0; b < DB; b++)
      begin
        data_reg[b] <= data_next[b];
      end
    end
  end

  // ------------------------------------------------------------
  // destination resolution
  // ------------------------------------------------------------
  logic [2:0] res_ports_reg;
  logic [2:0] res_ports_next;
  logic       res_valid_reg;
  logic       res_valid_next;
  logic       res_drop_reg;
  logic       res_drop_next;
  logic       res_ovr_reg;
  logic       res_ovr_next;
  logic       res_static_reg;
  logic       res_static_next;
  logic       res_learn_reg;
  logic       res_learn_next;

  logic [EW-1:0] ent;
  logic          st_hit;
  logic [EW-1:0] st_ent;
  logic [2:0]    ingress_mask;
  logic [2:0]    mask_sel;
  logic          bad_vlan;

  always_comb
  begin
    st_hit = 1'b0;
    st_ent = '0;
    ent    = '0;
    // scan downward so the lowest matching index is taken last
    for (int i = NE-1; i >= 0; i--)
    begin
      ent = mem_bus.entries[i*EW +: EW];
      if (ent[sml_pkg::VALID_BIT] &&
          (ent[sml_pkg::MAC_LSB +: sml_pkg::MAC_W] == destination_station_i) &&
          (!ent[sml_pkg::USEGRP_BIT] ||
           (ent[sml_pkg::GRP_LSB +: sml_pkg::GRP_W] == filter_group_id_i)))
      begin
        st_hit = 1'b1;
        st_ent = ent;
      end
    end
  end

  assign ingress_mask = 3'(1) << origin_port_i;
  assign bad_vlan     = vlan_mode_i && !vlan_valid_i;

  always_comb
  begin
    res_valid_next  = lookup_req_i;
    res_ports_next  = res_ports_reg;
    res_drop_next   = res_drop_reg;
    res_ovr_next    = res_ovr_reg;
    res_static_next = res_static_reg;
    res_learn_next  = 1'b0;
    mask_sel        = '0;
    if (lookup_req_i)
    begin
      res_ovr_next    = 1'b0;
      res_static_next = 1'b0;
      res_drop_next   = 1'b0;
      // source side uses only the dynamic result
      res_learn_next  = !src_dyn_hit_i && !bad_vlan;
      // invalid tag: configured ports minus ingress, drop when none remain
      if (bad_vlan)
      begin
        mask_sel      = bad_vlan_port_mask_reg & ~ingress_mask;
        res_drop_next = (mask_sel == '0);
      end
      else if (st_hit)
      begin
        mask_sel        = st_ent[sml_pkg::PORTS_LSB +: sml_pkg::PORT_CNT];
        res_ovr_next    = st_ent[sml_pkg::OVR_BIT];
        res_static_next = 1'b1;
        if (mask_sel == sml_pkg::PORTS_ALL)
        begin
          mask_sel = sml_pkg::PORTS_ALL & ~ingress_mask;
        end
      end
      else if (dyn_hit_i)
      begin
        mask_sel = dyn_ports_i;
      end
      else
      begin
        mask_sel = vlan_members_i & ~ingress_mask;
      end
      res_ports_next = res_drop_next ? 3'h0 : mask_sel;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      res_valid_reg  <= 1'b0;
      res_ports_reg  <= '0;
      res_drop_reg   <= 1'b0;
      res_ovr_reg    <= 1'b0;
      res_static_reg <= 1'b0;
      res_learn_reg  <= 1'b0;
    end
    else
    begin
      res_valid_reg  <= res_valid_next;
      res_ports_reg  <= res_ports_next;
      res_drop_reg   <= res_drop_next;
      res_ovr_reg    <= res_ovr_next;
      res_static_reg <= res_static_next;
      res_learn_reg  <= res_learn_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata_o      = rdata_reg;
  assign reg_rvalid_o     = rvalid_reg;
  assign fwd_valid_o      = res_valid_reg;
  assign fwd_ports_o      = res_ports_reg;
  assign fwd_drop_o       = res_drop_reg;
  assign fwd_override_o   = res_ovr_reg;
  assign fwd_static_hit_o = res_static_reg;
  assign learn_source_o   = res_learn_reg;
  assign tag_insert_o     = tag_reg;

endmodule // sml_lookup_top

`default_nettype wire

// file: hw/sml_mem_if.sv
// Purpose: connection between the lookup core and the entry store
// Assumes: single clock domain
// Notes: write and read strobes are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none

interface sml_mem_if #(
  parameter int DEPTH = sml_pkg::ENTRIES,
  parameter int WIDTH = sml_pkg::ENTRY_W,
  parameter int AW    = sml_pkg::IDX_W
);
  logic             we;
  logic [AW-1:0]    waddr;
  logic [WIDTH-1:0] wdata;
  logic             re;
  logic [AW-1:0]    raddr;
  logic [WIDTH-1:0] rdata;
  logic [DEPTH*WIDTH-1:0] entries;

  modport core (output we, output waddr, output wdata, output re, output raddr,
                input rdata, input entries);
  modport mem  (input we, input waddr, input wdata, input re, input raddr,
                output rdata, output entries);
endinterface

`default_nettype wire

// file: hw/sml_pkg.sv
// Purpose: constants and layouts of the static station table and forwarding controls
// Assumes: 8-bit register port, one 100 MHz switch clock
// Notes: shared by sml_lookup_top and sml_entry_mem
// Operation
// - every destination lookup consults the static table and the learned dynamic table result; the code uses neither for invalid-vlan frames in vlan mode.
// - source lookups use only the dynamic table result and never the static entries.
// - a destination hit in both tables takes the static result and drops the dynamic one.
// - static entries are never aged or removed by the hardware, only by software writes.
// - the static table holds eight 58-bit entries whose bits 47-0 are the station address.
// - entry bits 57-54 hold a four-bit filter group id that resets to zero.
// - with entry bit 53 set a hit needs both group id and address to match, else the address alone.
// - entry bit 52 set lets hits bypass the port transmit and receive enables.
// - only entries with bit 51 set are used, and that bit resets to zero.
// - entry bits 50-48 are the port mask for ports 1 to 3, and 111 means all but the ingress port.
// - bits 6-4 of the invalid-tag register give the ports for frames with an invalid vlan id, reset zero.
// - tag-insert bits 2, 1 and 0 insert the port 2 tag at port 3, port 3 tag at port 1 and port 3 tag at port 2.
// - tag-insert bits 5, 4 and 3 insert the port 1 tag at port 2, port 1 tag at port 3 and port 2 tag at port 1.
// - in vlan mode a frame with an invalid vlan id goes to the invalid-tag ports minus ingress, dropped if none remain; its source is not learned.

package sml_pkg;

  // ------------------------------------------------------------
  // table geometry and entry fields
  // ------------------------------------------------------------
  localparam int ENTRIES    = 8;
  localparam int IDX_W      = 3;
  localparam int ENTRY_W    = 58;
  localparam int MAC_LSB    = 0;
  localparam int MAC_W      = 48;
  localparam int PORTS_LSB  = 48;
  localparam int PORT_CNT   = 3;
  localparam int VALID_BIT  = 51;
  localparam int OVR_BIT    = 52;
  localparam int USEGRP_BIT = 53;
  localparam int GRP_LSB    = 54;
  localparam int GRP_W      = 4;
  localparam logic [ENTRY_W-1:0] ENTRY_RESET = 58'h0;
  localparam logic [PORT_CNT-1:0] PORTS_ALL  = 3'h7;

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam int REG_W     = 8;
  localparam int DATA_BYTES = 8;
  localparam int TOP_BYTE_W = 2;
  localparam logic [7:0] ADDR_TBL_CTRL   = 8'h79;
  localparam logic [7:0] ADDR_TBL_INDEX  = 8'h7a;
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h7c;
  localparam logic [7:0] ADDR_TAG_INSERT = 8'hc2;
  localparam logic [7:0] ADDR_BAD_VLAN   = 8'hc6;
  localparam int CTRL_READ_BIT = 4;
  localparam int CTRL_SEL_LSB  = 2;
  localparam logic [1:0] SEL_STATIC = 2'h0;
  localparam int TAG_INSERT_W  = 6;
  localparam int BAD_VLAN_LSB  = 4;
  localparam logic [7:0] REG_RESET = 8'h00;

endpackage
